// [rtl/msf_receiver.sv]
// Set-top receiver: unwraps and reassembles sections carried in datagrams
//
// Function
// - Wrapper header is marker, version, final flag, piece index, section tag.
// - Marker byte is 0xff; anything else is not a wrapper header.
// - Final flag ends the section carrying the same tag.
// - Piece index zero starts a section; later pieces count upward.
// - Index zero with final flag is a whole unsegmented section.
// - Pieces group only when both addresses, both ports and tag match.
// - Receiver reassembles four segmented sections at once without loss.
// - Controller maps transport id and table id to group address and port.
// - Carousel tunnels start every datagram with the carousel header.
// - Carousel header is version 0x1, reserved one, 13-bit packet identifier.
`timescale 1ns/1ps
`default_nettype none

module msf_receiver
   import msf_pkg::*;
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rstn,
   // Datagram payload in, one byte per beat, after UDP header removal
   input  wire logic                dg_valid,
   input  wire logic [7:0]          dg_data,
   input  wire logic                dg_first,
   input  wire logic                dg_last,
   input  wire logic [31:0]         dg_src_ip,
   input  wire logic [15:0]         dg_src_port,
   input  wire logic [31:0]         dg_dst_ip,
   input  wire logic [15:0]         dg_dst_port,
   // Tunnel mode and flow selection
   input  wire logic                carousel_mode,
   input  wire logic                map_valid,
   input  wire logic [12:0]         req_pid,
   input  wire logic [7:0]          req_table_id,
   input  wire logic [12:0]         map_pid,
   input  wire logic [7:0]          map_table_id,
   input  wire logic [31:0]         map_group_ip,
   input  wire logic [15:0]         map_port,
   // Section read port
   input  wire logic                rd_en,
   input  wire logic [ADDR_W-1:0]   rd_addr,
   output logic [7:0]               rd_data,
   // Section completion
   output logic                     sec_done,
   output logic [SLOT_W-1:0]        sec_slot,
   output logic [LEN_W-1:0]         sec_len,
   output logic [15:0]              sec_tag,
   output logic [12:0]              sec_pid,
   // Status
   output logic                     hdr_error,
   output logic                     flow_pass,
   output logic [NUM_SLOTS-1:0]     slots_busy
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   msf_state_t                state_reg;
   logic [2:0]                hcnt_reg;
   logic [7:0]                hdr_reg [HDR_BYTES];
   logic [KEY_W-1:0]          key;
   logic                      hit, free_ok;
   logic [SLOT_W-1:0]         hit_slot, free_slot;
   logic                      claim, release_en;
   logic [SLOT_W-1:0]         cur_slot_reg;
   logic [SLOT_W-1:0]         upd_slot_sel;
   logic [LEN_W-1:0]          wlen_reg [NUM_SLOTS];
   logic [3:0]                next_piece_reg [NUM_SLOTS];
   logic [7:0]                mem [NUM_SLOTS][MAX_SECTION];
   logic                      is_final_reg;
   logic [12:0]               pid_reg;
   logic [NUM_SLOTS-1:0]      busy;
   logic                      hdr_ok;
   logic [3:0]                piece;
   logic                      final_f;
   logic                      flow_match;

   assign key = {dg_src_ip, dg_src_port, dg_dst_ip, dg_dst_port,
                 hdr_reg[2], hdr_reg[3]};
   assign piece   = hdr_reg[1][PIECE_MSB:PIECE_LSB];
   assign final_f = hdr_reg[1][FINAL_BIT];

   // Marker must be the forbidden table id except in carousel mode, which checks the reserved bit; version is also checked
   assign hdr_ok = carousel_mode
      ? (hdr_reg[0][CAR_VER_MSB:CAR_VER_LSB] == CAR_VERSION
         && hdr_reg[0][CAR_RSV_BIT])
      : (hdr_reg[0] == MARKER_BYTE
         && hdr_reg[1][VER_MSB:VER_LSB] == HDR_VERSION);

   // Requested flow mapping; only flows on the mapped group and port pass
   assign flow_match = map_valid && (req_pid == map_pid)
      && (req_table_id == map_table_id)
      && (dg_dst_ip == map_group_ip) && (dg_dst_port == map_port);

   msf_slot_table u_slots
   (
      .clk        (clk),
      .rstn       (rstn),
      .key        (key),
      .hit        (hit),
      .hit_slot   (hit_slot),
      .free_ok    (free_ok),
      .free_slot  (free_slot),
      .claim      (claim),
      .release_en (release_en),
      .upd_slot   (upd_slot_sel),
      .busy       (busy)
   );

   // ------------------------------------------------------------
   // Header parse and slot decision
   // ------------------------------------------------------------
   // Slot is decided once the last header byte is in; carousel uses slot 0
   logic hdr_end;
   logic [SLOT_W-1:0] pick_slot;
   logic              pick_ok;
   logic              first_piece;
   assign hdr_end = (state_reg == MSF_HDR) && !dg_valid;
   assign first_piece = (piece == FIRST_PIECE);
   always_comb
   begin
      pick_slot = '0;
      pick_ok   = 1'b0;
      if (carousel_mode)
         pick_ok = 1'b1;
      else if (hit)
      begin
         pick_slot = hit_slot;
         pick_ok   = first_piece
                     || (piece == next_piece_reg[hit_slot]);
      end
      else if (first_piece && free_ok)
      begin
         pick_slot = free_slot;
         pick_ok   = 1'b1;
      end
   end

   assign claim = hdr_end && hdr_ok && pick_ok && !carousel_mode && !hit;
   assign release_en = (state_reg == MSF_DONE) && is_final_reg && !carousel_mode;

   // A claim must write the slot picked in this cycle, not the one still in use
   assign upd_slot_sel = claim ? pick_slot : cur_slot_reg;

   // Parse state machine: header bytes gathered in a separate beat count
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         state_reg <= MSF_IDLE;
      else
      begin
         unique case (state_reg)
            MSF_IDLE:
               if (dg_valid && dg_first)
                  state_reg <= MSF_HDR;
            MSF_HDR:
               if (hdr_end)
                  state_reg <= (hdr_ok && pick_ok) ? MSF_BODY : MSF_DROP;
               else if (dg_valid && dg_last)
                  state_reg <= MSF_DROP;
            MSF_BODY:
               if (dg_valid && dg_last)
                  state_reg <= MSF_DONE;
            MSF_DROP:
               if (!dg_valid || dg_last)
                  state_reg <= MSF_IDLE;
            MSF_DONE:
               state_reg <= MSF_IDLE;
         endcase
      end
   end

   // Header byte capture; the byte count stops at the header length
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         hcnt_reg <= '0;
         for (int i = 0; i < HDR_BYTES; i++)
            hdr_reg[i] <= '0;
      end
      else if (dg_valid && dg_first)
      begin
         hdr_reg[0] <= dg_data;
         hcnt_reg   <= 3'h1;
      end
      // Bytes past the header length are not kept, so the index stays in range
      else if (dg_valid && state_reg == MSF_HDR && hcnt_reg < 3'(HDR_BYTES))
      begin
         hdr_reg[hcnt_reg[1:0]] <= dg_data;
         hcnt_reg <= hcnt_reg + 3'h1;
      end
   end

   // Header done is marked by the first pause beat, whether or not header length is reached
   // Limitation: the source must leave one idle beat after the header bytes.

   // ------------------------------------------------------------
   // Section storage
   // ------------------------------------------------------------
   // Write pointer per slot; a first piece rewinds it, dropping stale data
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cur_slot_reg <= '0;
         is_final_reg <= 1'b0;
         pid_reg      <= '0;
         for (int s = 0; s < NUM_SLOTS; s++)
         begin
            wlen_reg[s]       <= '0;
            next_piece_reg[s] <= '0;
         end
      end
      else if (hdr_end && hdr_ok && pick_ok)
      begin
         cur_slot_reg <= pick_slot;
         is_final_reg <= carousel_mode ? 1'b1 : final_f;
         pid_reg      <= {hdr_reg[0][CAR_PID_MSB:0], hdr_reg[1]};
         if (carousel_mode || first_piece)
            wlen_reg[pick_slot] <= '0;
         next_piece_reg[pick_slot] <= piece + 4'h1;
      end
      else if (state_reg == MSF_BODY && dg_valid
               && wlen_reg[cur_slot_reg] < LEN_W'(MAX_SECTION))
         wlen_reg[cur_slot_reg] <= wlen_reg[cur_slot_reg] + LEN_W'(1);
   end

   // Payload memory; bytes past the section limit are discarded
   always_ff @(posedge clk)
   begin
      if (state_reg == MSF_BODY && dg_valid
          && wlen_reg[cur_slot_reg] < LEN_W'(MAX_SECTION))
         mem[cur_slot_reg][wlen_reg[cur_slot_reg][ADDR_W-1:0]] <= dg_data;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Completion pulse when the final piece of a section has been stored
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sec_done <= 1'b0;
         sec_slot <= '0;
         sec_len  <= '0;
         sec_tag  <= '0;
         sec_pid  <= '0;
      end
      else
      begin
         sec_done <= (state_reg == MSF_DONE) && is_final_reg;
         if ((state_reg == MSF_DONE) && is_final_reg)
         begin
            sec_slot <= cur_slot_reg;
            sec_len  <= wlen_reg[cur_slot_reg];
            sec_tag  <= {hdr_reg[2], hdr_reg[3]};
            sec_pid  <= pid_reg;
         end
      end
   end

   // Read data is registered, so it lags rd_en by one cycle
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rd_data <= '0;
      else if (rd_en)
         rd_data <= mem[sec_slot][rd_addr];
   end

   // Status flags
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         hdr_error  <= 1'b0;
         flow_pass  <= 1'b0;
         slots_busy <= '0;
      end
      else
      begin
         hdr_error  <= hdr_end && !hdr_ok;
         flow_pass  <= flow_match;
         slots_busy <= busy;
      end
   end

endmodule

`default_nettype wire

// [rtl/msf_pkg.sv]
// Package: constants and types for the section-over-datagram receiver
package msf_pkg;

   // ------------------------------------------------------------
   // Broadcast wrapper header layout
   // ------------------------------------------------------------
   localparam int          HDR_BYTES      = 4;
   localparam logic [7:0]  MARKER_BYTE    = 8'hff;
   localparam logic [2:0]  HDR_VERSION    = 3'h1;
   localparam int          VER_MSB        = 7;
   localparam int          VER_LSB        = 5;
   localparam int          FINAL_BIT      = 4;
   localparam int          PIECE_MSB      = 3;
   localparam int          PIECE_LSB      = 0;
   localparam logic [3:0]  FIRST_PIECE    = 4'h0;

   // ------------------------------------------------------------
   // Carousel wrapper header layout
   // ------------------------------------------------------------
   localparam int          CAR_HDR_BYTES  = 2;
   localparam logic [1:0]  CAR_VERSION    = 2'h1;
   localparam int          CAR_VER_MSB    = 7;
   localparam int          CAR_VER_LSB    = 6;
   localparam int          CAR_RSV_BIT    = 5;
   localparam int          CAR_PID_MSB    = 4;

   // ------------------------------------------------------------
   // Reassembly sizing
   // ------------------------------------------------------------
   localparam int          NUM_SLOTS      = 4;
   localparam int          SLOT_W         = 2;
   localparam int          MAX_SECTION    = 4096;
   localparam int          LEN_W          = 13;
   localparam int          ADDR_W         = 12;
   localparam int          KEY_W          = 112;

   // Receive parse states
   typedef enum logic [2:0] {
      MSF_IDLE,
      MSF_HDR,
      MSF_BODY,
      MSF_DROP,
      MSF_DONE
   } msf_state_t;

endpackage

// [rtl/msf_slot_table.sv]
// Reassembly slot table: stream key match and slot allocation
`timescale 1ns/1ps
`default_nettype none

module msf_slot_table
   import msf_pkg::*;
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rstn,
   // Lookup
   input  wire logic [KEY_W-1:0]    key,
   output logic                     hit,
   output logic [SLOT_W-1:0]        hit_slot,
   output logic                     free_ok,
   output logic [SLOT_W-1:0]        free_slot,
   // Update
   input  wire logic                claim,
   input  wire logic                release_en,
   input  wire logic [SLOT_W-1:0]   upd_slot,
   output logic [NUM_SLOTS-1:0]     busy
);

   logic [KEY_W-1:0]     key_reg [NUM_SLOTS];
   logic [NUM_SLOTS-1:0] busy_reg;
   logic [NUM_SLOTS-1:0] match;

   // Match on all five stream fields at once
   genvar g;
   generate
      for (g = 0; g < NUM_SLOTS; g++)
      begin : g_slot
         assign match[g] = busy_reg[g] && (key_reg[g] == key);
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
               key_reg[g] <= '0;
            else if (claim && (upd_slot == SLOT_W'(g)))
               key_reg[g] <= key;
         end
      end
   endgenerate

   // Priority pick of a hit and of the lowest free slot
   always_comb
   begin
      hit       = 1'b0;
      hit_slot  = '0;
      free_ok   = 1'b0;
      free_slot = '0;
      for (int i = NUM_SLOTS - 1; i >= 0; i--)
      begin
         if (match[i])
         begin
            hit      = 1'b1;
            hit_slot = SLOT_W'(i);
         end
         if (!busy_reg[i])
         begin
            free_ok   = 1'b1;
            free_slot = SLOT_W'(i);
         end
      end
   end

   // Occupancy; a claim in the same cycle as a release keeps the slot busy
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         busy_reg <= '0;
      else
      begin
         if (release_en)
            busy_reg[upd_slot] <= 1'b0;
         if (claim)
            busy_reg[upd_slot] <= 1'b1;
      end
   end

   assign busy = busy_reg;

endmodule

`default_nettype wire

// [verification/msf_receiver_sva.sv]
// Checker: timing and field relations at the receiver ports
`timescale 1ns/1ps
`default_nettype none
module msf_receiver_sva
   import msf_pkg::*;
(
   // Clock and reset
   input wire logic                 clk,
   input wire logic                 rstn,
   // Datagram input
   input wire logic                 dg_valid,
   input wire logic [7:0]           dg_data,
   input wire logic                 dg_first,
   input wire logic                 dg_last,
   input wire logic                 carousel_mode,
   input wire logic                 map_valid,
   // Results
   input wire logic                 sec_done,
   input wire logic [LEN_W-1:0]     sec_len,
   input wire logic [15:0]          sec_tag,
   input wire logic [12:0]          sec_pid,
   input wire logic                 hdr_error,
   input wire logic                 flow_pass,
   input wire logic [NUM_SLOTS-1:0] slots_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [12:0] bcnt;
   logic [7:0]  b0;
   logic [7:0]  b1;
   logic [15:0] tag_q;
   // ----------------------------------------------------
   // Header shadow
   // ----------------------------------------------------
   // Latest header kept so each completion can be judged against it
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bcnt <= '0;
         b0 <= '0;
         b1 <= '0;
         tag_q <= '0;
      end
      else if (dg_valid)
      begin
         bcnt <= dg_first ? 13'h1 : bcnt + 13'h1;
         if (dg_first)
            b0 <= dg_data;
         if (!dg_first && bcnt == 13'h1)
            b1 <= dg_data;
         if (!dg_first && bcnt == 13'h2)
            tag_q[15:8] <= dg_data;
         if (!dg_first && bcnt == 13'h3)
            tag_q[7:0] <= dg_data;
      end
   end
   // ----------------------------------------------------
   // Properties
   // ----------------------------------------------------
   property p_done_lat;
      sec_done |-> $past(dg_valid && dg_last, 2);
   endproperty
   a_done_lat: assert property (p_done_lat)
      else $error("completion not two cycles after last byte");
   property p_final;
      sec_done && !carousel_mode |-> b1[FINAL_BIT] && b0 == MARKER_BYTE;
   endproperty
   a_final: assert property (p_final)
      else $error("completion without final flag or marker");
   property p_tag;
      sec_done && !carousel_mode |-> sec_tag == tag_q;
   endproperty
   a_tag: assert property (p_tag)
      else $error("section tag differs from header");
   property p_unseg;
      sec_done && !carousel_mode && b1[PIECE_MSB:PIECE_LSB] == FIRST_PIECE
         |-> sec_len == bcnt - 13'(HDR_BYTES);
   endproperty
   a_unseg: assert property (p_unseg)
      else $error("whole section length wrong");
   property p_marker;
      hdr_error && !carousel_mode |-> b0 != MARKER_BYTE || b1[VER_MSB:VER_LSB] != HDR_VERSION;
   endproperty
   a_marker: assert property (p_marker)
      else $error("header error on a good header");
   property p_pid;
      sec_done && carousel_mode |-> sec_pid == {b0[CAR_PID_MSB:0], b1}
         && sec_len == bcnt - 13'(CAR_HDR_BYTES);
   endproperty
   a_pid: assert property (p_pid)
      else $error("carousel identifier or length wrong");
   property p_hold;
      !sec_done |-> $stable(sec_len) && $stable(sec_tag);
   endproperty
   a_hold: assert property (p_hold)
      else $error("completion fields moved between completions");
   property p_busy;
      $countones(slots_busy) <= $countones($past(slots_busy)) + 1;
   endproperty
   a_busy: assert property (p_busy)
      else $error("more than one slot claimed at once");
   property p_flow;
      !map_valid |=> !flow_pass;
   endproperty
   a_flow: assert property (p_flow)
      else $error("flow passed without a mapping");
   c_unseg: cover property (sec_done && !carousel_mode);
   c_car: cover property (sec_done && carousel_mode);
   c_err: cover property (hdr_error);
   c_full: cover property (slots_busy == 4'hf);
endmodule
`default_nettype wire

// [verification/msf_sender_model.sv]
// Headend sender model: drives wrapped datagram bytes into the receiver
`timescale 1ns/1ps
`default_nettype none
module msf_sender_model
(
   // Clock
   input  wire logic   clk,
   // Datagram stream
   output logic        dg_valid,
   output logic [7:0]  dg_data,
   output logic        dg_first,
   output logic        dg_last,
   output logic [15:0] dg_src_port
);
   initial
   begin
      dg_valid = 1'b0;
      dg_data = 8'h00;
      dg_first = 1'b0;
      dg_last = 1'b0;
      dg_src_port = 16'h0000;
   end
   // One whole datagram: header, one gap beat, body; one section piece per datagram
   // Released data is inverted so a stale byte can never pass for a fresh one
   task automatic send(input logic [31:0] hdr, input int nh, input int nb,
                       input logic [15:0] port);
      for (int i = 0; i < nh + 1 + nb; i++)
      begin
         @(negedge clk);
         dg_src_port = port;
         dg_valid = (i != nh);
         dg_first = (i == 0);
         dg_last = (i == nh + nb);
         dg_data = (i < nh) ? hdr[31-8*i -: 8] : (i == nh) ? ~dg_data : port[7:0] + 8'(i);
      end
      @(negedge clk);
      dg_valid = 1'b0;
      dg_last = 1'b0;
      dg_data = ~dg_data;
   endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Testbench: sender model drives the receiver through section scenarios
`timescale 1ns/1ps
`default_nettype none
module testbench import msf_pkg::*;;
   logic                 clk, rstn, dg_valid, dg_first, dg_last, carousel_mode, map_valid;
   logic                 rd_en, sec_done, hdr_error, flow_pass;
   logic [7:0]           dg_data, req_table_id, map_table_id, rd_data;
   logic [15:0]          dg_src_port, dg_dst_port, map_port, sec_tag;
   logic [31:0]          dg_src_ip, dg_dst_ip, map_group_ip;
   logic [12:0]          req_pid, map_pid, sec_pid;
   logic [ADDR_W-1:0]    rd_addr;
   logic [SLOT_W-1:0]    sec_slot;
   logic [LEN_W-1:0]     sec_len;
   logic [NUM_SLOTS-1:0] slots_busy;
   int                   error_cnt = 0;
   int                   num_checks = 0;
   int                   n_err = 0;
   msf_sender_model sndr_u (.clk, .dg_valid, .dg_data, .dg_first, .dg_last, .dg_src_port);
   msf_receiver dut_u (.clk, .rstn, .dg_valid, .dg_data, .dg_first, .dg_last, .dg_src_ip,
      .dg_src_port, .dg_dst_ip, .dg_dst_port, .carousel_mode, .map_valid, .req_pid,
      .req_table_id, .map_pid, .map_table_id, .map_group_ip, .map_port, .rd_en, .rd_addr,
      .rd_data, .sec_done, .sec_slot, .sec_len, .sec_tag, .sec_pid, .hdr_error, .flow_pass,
      .slots_busy);
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Header errors are one-cycle pulses, so count them as they pass
   always @(negedge clk)
      if (hdr_error === 1'b1)
         n_err++;
   // ----------------------------------------------------
   // Tasks
   // ----------------------------------------------------
   function automatic logic [31:0] bh(input logic fin, input logic [3:0] pc, input logic [15:0] t);
      return {MARKER_BYTE, HDR_VERSION, fin, pc, t};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Bounded wait for a completion pulse
   task automatic wait_done();
      int k;
      k = 0;
      while (sec_done !== 1'b1 && k < 20)
      begin
         @(negedge clk);
         k++;
      end
      if (sec_done !== 1'b1)
      begin
         error_cnt++;
         end_sim();
      end
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(negedge clk);
      rd_en = 1'b1;
      rd_addr = a;
      @(negedge clk);
      rd_en = 1'b0;
   endtask
   // ----------------------------------------------------
   // Scenarios
   // ----------------------------------------------------
   initial
   begin
      {rstn, carousel_mode, map_valid, rd_en, rd_addr} = '0;
      {req_pid, map_pid, req_table_id, map_table_id} = {13'h0042, 13'h0042, 8'hc2, 8'hc2};
      {dg_src_ip, dg_dst_ip, map_group_ip} = {32'h0a000001, 32'he0000001, 32'he0000001};
      {dg_dst_port, map_port} = {16'h1f40, 16'h1f40};
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      sndr_u.send(bh(1'b1, 4'h0, 16'h1234), 4, 5, 16'h0010);
      wait_done();
      chk(sec_len, 5);
      chk(sec_tag, 16'h1234);
      rd(12'h004);
      chk(rd_data, 8'h19);
      $display("test whole section done");
      for (int i = 0; i < 2; i++)
      begin
         sndr_u.send({i ? MARKER_BYTE : 8'hfe, i ? 3'h2 : HDR_VERSION, 21'h101234}, 4, 2, 16'h20);
         repeat (3) @(negedge clk);
         chk(n_err, i + 1);
      end
      $display("test bad header done");
      for (int p = 0; p < 4; p++)
         sndr_u.send(bh(1'b0, 4'h0, 16'(p)), 4, 3, 16'(p));
      @(negedge clk);
      chk(slots_busy, 4'hf);
      // Same tag, foreign port: must not join stream zero
      sndr_u.send(bh(1'b1, 4'h1, 16'h0), 4, 2, 16'h0009);
      for (int p = 0; p < 4; p++)
      begin
         sndr_u.send(bh(1'b1, 4'h1, 16'(p)), 4, 2, 16'(p));
         wait_done();
         chk(sec_len, 5);
         chk(sec_tag, 16'(p));
         rd(12'h003);
         chk(rd_data, 8'(p + 5));
      end
      @(negedge clk);
      chk(slots_busy, 4'h0);
      $display("test four streams done");
      sndr_u.send(bh(1'b0, 4'h0, 16'h0077), 4, 3, 16'h0030);
      sndr_u.send(bh(1'b0, 4'h0, 16'h0077), 4, 2, 16'h0030);
      sndr_u.send(bh(1'b1, 4'h1, 16'h0077), 4, 2, 16'h0030);
      wait_done();
      chk(sec_len, 4);
      rd(12'h002);
      chk(rd_data, 8'h35);
      $display("test restart done");
      carousel_mode = 1'b1;
      sndr_u.send({CAR_VERSION, 1'b1, 13'h0abc, 16'h0}, 2, 3, 16'h0040);
      wait_done();
      chk(sec_pid, 13'h0abc);
      chk(sec_len, 3);
      chk(sec_slot, 2'h0);
      // Reserved bit clear: not a carousel header, so the datagram is refused
      sndr_u.send({CAR_VERSION, 1'b0, 13'h0abc, 16'h0}, 2, 3, 16'h0040);
      repeat (3) @(negedge clk);
      chk(n_err, 3);
      chk(sec_pid, 13'h0abc);
      // Mode only changes once the last completion has passed the checker
      carousel_mode = 1'b0;
      $display("test carousel done");
      map_valid = 1'b1;
      repeat (2) @(negedge clk);
      chk(flow_pass, 1'b1);
      dg_dst_port = 16'h1f41;
      repeat (2) @(negedge clk);
      chk(flow_pass, 1'b0);
      dg_dst_port = 16'h1f40;
      req_table_id = 8'hc3;
      repeat (2) @(negedge clk);
      chk(flow_pass, 1'b0);
      req_table_id = 8'hc2;
      repeat (2) @(negedge clk);
      chk(flow_pass, 1'b1);
      $display("test flow map done");
      end_sim();
   end
endmodule
bind msf_receiver msf_receiver_sva chk_u (.clk, .rstn, .dg_valid, .dg_data, .dg_first,
   .dg_last, .carousel_mode, .map_valid, .sec_done, .sec_len, .sec_tag, .sec_pid,
   .hdr_error, .flow_pass, .slots_busy);
`default_nettype wire
